// [inc/dsar_pkg.sv]
// ------------------------------------------------------------------
// Shared constants and types of the dual-channel converter control
// ------------------------------------------------------------------
package dsar_pkg;

    // Result layout
    localparam int RES_W      = 16;
    localparam int SER_BITS   = 32;
    localparam int SER_CNT_W  = 6;
    localparam int BIT_IDX_W  = 4;
    localparam int MSB_IDX    = RES_W - 1;
    localparam int LO_BYTE_HI = 7;
    localparam int HI_BYTE_LO = 8;

    // Code limits, straight binary
    localparam logic [15:0] CODE_ZERO = 16'h0000;
    localparam logic [15:0] CODE_MID  = 16'h8000;

    // Timing in nanoseconds at the system clock
    localparam int CLK_PERIOD_NS = 40;
    localparam int BIT_TIME_NS   = 80;
    localparam int ACQ_TIME_NS   = 600;

    // Least time rounds up, never below one cycle
    function automatic int dsar_min_cycles(input int t_ns);
        int c;
        c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : dsar_min_cycles

    localparam int BIT_CYCLES = dsar_min_cycles(BIT_TIME_NS);
    localparam int ACQ_CYCLES = dsar_min_cycles(ACQ_TIME_NS);
    localparam int TMR_W      = 8;

    // Buffer depth fixed at two words
    localparam int BUF_DEPTH  = 2;

    // Conversion sequencer states
    typedef enum logic [1:0] {
        DSAR_IDLE,
        DSAR_ACQ,
        DSAR_CONV_A,
        DSAR_CONV_B
    } dsar_state_type;

endpackage : dsar_pkg

// [src/dsar_ctrl.sv]
`timescale 1ns/1ps

// What this block does
// - Started conversion completes unless device reset aborts it, never restarted
// - Start works regardless of chip select, read
// - Low-power held strobe self-times acquisition, repeats
// - Self-repeat may exceed guaranteed rate slightly
// - No self-repeat in full-rate mode
// - Low-power mode drops power after conversion
// - Host interface stays alive during acquisition
// - Outputs float unless select and read low
// - Channel pick chooses word or order
// - Reset aborts conversion, floats data bus
// - Select low parallel, high serial
// - Tied-low controls drive latest result continuously
// - Slave reads after or during conversion
// - Byte order select swaps result bytes on the parallel bus
// - Pick high first channel, low second
// - First channel readable on its completion in parallel mode
// - Serial first word refreshed after second done
// - Serial shifts 32 bits, MSB first
// - Serial order follows channel pick input
// - Pair select low first pair, high second
// - First channel always converted before second
// - Results straight binary, zeros lowest input
module dsar_ctrl #(
    parameter int RES_W      = dsar_pkg::RES_W,
    parameter int BIT_CYCLES = dsar_pkg::BIT_CYCLES,
    parameter int ACQ_CYCLES = dsar_pkg::ACQ_CYCLES
) (
    input  wire logic             sys_clk_i,
    input  wire logic             nrst_i,
    input  wire logic             conv_start_n_i,
    input  wire logic             power_down_in_i,
    input  wire logic             dev_reset_i,
    input  wire logic             low_power_mode_i,
    input  wire logic             cs_n_i,
    input  wire logic             rd_n_i,
    input  wire logic             serial_parallel_sel_i,
    input  wire logic             byte_order_sel_i,
    input  wire logic             chan_pick_i,
    input  wire logic             input_pair_sel_i,
    input  wire logic             comparator_i,
    input  wire logic             serial_clk_i,
    output logic                  busy_o,
    output logic                  chan_done_o,
    output logic                  low_power_o,
    output logic                  track_o,
    output logic                  conv_chan_o,
    output logic                  pair_sel_o,
    output logic [RES_W-1:0]      dac_code_o,
    output logic [RES_W-1:0]      data_o,
    output logic                  data_oe_o,
    output logic                  serial_out_o,
    output logic                  serial_out_oe_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    // Sequencer
    dsar_pkg::dsar_state_type state_q, state_d, state_nx;
    logic                        start_n_q;
    logic                        armed_q;
    logic [dsar_pkg::TMR_W-1:0]  tmr_q, tmr_d;
    logic [dsar_pkg::BIT_IDX_W-1:0] bit_q, bit_d;
    logic [RES_W-1:0]            trial_q, trial_d;
    // Result buffer and output words
    logic [RES_W-1:0]            buf_mem_q [dsar_pkg::BUF_DEPTH];
    logic                        buf_wptr_q, buf_rptr_q;
    logic [1:0]                  buf_cnt_q;
    logic [RES_W-1:0]            word_a_q, word_b_q;
    logic                        pop_second_q;
    // Serial shifter
    logic [dsar_pkg::SER_BITS-1:0] shift_q;
    logic [dsar_pkg::SER_CNT_W-1:0] shift_cnt_q;
    logic                        sclk_q;

    // ------------------------------------------------------------------
    // Shared decode
    // ------------------------------------------------------------------
    // Converting states, looked at both before and after the register
    function automatic logic dsar_is_conv(input dsar_pkg::dsar_state_type st);
        return (st == dsar_pkg::DSAR_CONV_A) | (st == dsar_pkg::DSAR_CONV_B);
    endfunction : dsar_is_conv

    // ------------------------------------------------------------------
    // Start detection and sequencing decisions
    // ------------------------------------------------------------------
    // Falling edge only; cs and rd play no part here
    wire start_edge  = start_n_q & ~conv_start_n_i;
    // Buffer must be empty so both new words have room; this is the stall
    wire buf_in_rdy  = (buf_cnt_q < 2'(dsar_pkg::BUF_DEPTH));
    wire can_start   = (buf_cnt_q == 2'd0) & ~power_down_in_i;
    // Self-repeat only after a first edge and only in low-power mode
    wire auto_go     = low_power_mode_i & armed_q & ~conv_start_n_i;
    wire step_end    = (tmr_q == dsar_pkg::TMR_W'(BIT_CYCLES - 1));
    wire acq_end     = (tmr_q == dsar_pkg::TMR_W'(ACQ_CYCLES - 1));
    wire last_bit    = (bit_q == dsar_pkg::BIT_IDX_W'(0));
    wire converting  = dsar_is_conv(state_q);
    wire word_done   = converting & step_end & last_bit;
    // Final decision folded into the stored word
    wire [RES_W-1:0] bit_mask   = RES_W'(1) << bit_q;
    wire [RES_W-1:0] kept_code  = comparator_i ? trial_q : (trial_q & ~bit_mask);
    wire             buf_wr     = word_done & buf_in_rdy;

    // ------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        tmr_d   = tmr_q;
        bit_d   = bit_q;
        trial_d = trial_q;
        unique case (state_q)
            dsar_pkg::DSAR_IDLE: begin
                tmr_d = '0;
                // Power-down or an unread word holds off a start
                if (can_start & start_edge) begin
                    state_d = dsar_pkg::DSAR_CONV_A;
                    bit_d   = dsar_pkg::BIT_IDX_W'(dsar_pkg::MSB_IDX);
                    trial_d = dsar_pkg::CODE_MID;
                end else if (can_start & auto_go) begin
                    state_d = dsar_pkg::DSAR_ACQ;
                end
            end
            dsar_pkg::DSAR_ACQ: begin
                // Device times its own acquisition before relaunching
                tmr_d = tmr_q + 1'b1;
                if (acq_end) begin
                    state_d = dsar_pkg::DSAR_CONV_A;
                    tmr_d   = '0;
                    bit_d   = dsar_pkg::BIT_IDX_W'(dsar_pkg::MSB_IDX);
                    trial_d = dsar_pkg::CODE_MID;
                end
            end
            dsar_pkg::DSAR_CONV_A,
            dsar_pkg::DSAR_CONV_B: begin
                // Further strobes and power-down are ignored here
                tmr_d = tmr_q + 1'b1;
                if (step_end) begin
                    tmr_d = '0;
                    if (last_bit) begin
                        bit_d   = dsar_pkg::BIT_IDX_W'(dsar_pkg::MSB_IDX);
                        trial_d = dsar_pkg::CODE_MID;
                        state_d = (state_q == dsar_pkg::DSAR_CONV_A) ?
                                  dsar_pkg::DSAR_CONV_B : dsar_pkg::DSAR_IDLE;
                    end else begin
                        // Keep bit on high comparator, try next lower bit
                        bit_d   = bit_q - 1'b1;
                        trial_d = kept_code | (bit_mask >> 1);
                    end
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Sequencer registers; device reset aborts any conversion
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q   <= dsar_pkg::DSAR_IDLE;
            tmr_q     <= '0;
            bit_q     <= '0;
            trial_q   <= dsar_pkg::CODE_MID;
            // Idle strobe level, so release makes no false edge
            start_n_q <= 1'b1;
            armed_q   <= 1'b0;
        end else if (dev_reset_i) begin
            state_q   <= dsar_pkg::DSAR_IDLE;
            tmr_q     <= '0;
            bit_q     <= '0;
            trial_q   <= dsar_pkg::CODE_MID;
            start_n_q <= conv_start_n_i;
            armed_q   <= 1'b0;
        end else begin
            state_q   <= state_d;
            tmr_q     <= tmr_d;
            bit_q     <= bit_d;
            trial_q   <= trial_d;
            start_n_q <= conv_start_n_i;
            armed_q   <= armed_q | start_edge;
        end
    end

    // ------------------------------------------------------------------
    // Status and analog control outputs
    // ------------------------------------------------------------------
    // Device reset overrides the sequencer so status drops at once
    assign state_nx = dev_reset_i ? dsar_pkg::DSAR_IDLE : state_d;
    // Next-state decodes shared by the status flags
    wire nx_conv_a  = (state_nx == dsar_pkg::DSAR_CONV_A);
    wire nx_conv_b  = (state_nx == dsar_pkg::DSAR_CONV_B);
    wire nx_conv    = dsar_is_conv(state_nx);
    // Tracking covers idle and acquisition, the only other states
    wire nx_track   = ~nx_conv;
    // Power drops when a conversion ends, never in the middle of one
    wire nx_low_pwr = low_power_mode_i & ~nx_conv;
    // Aborted trial restarts from mid-scale
    wire [RES_W-1:0] nx_dac = dev_reset_i ? dsar_pkg::CODE_MID : trial_d;

    // Busy spans both channels; low power only outside conversion
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_o      <= 1'b0;
            chan_done_o <= 1'b0;
            low_power_o <= 1'b0;
            track_o     <= 1'b1;
            conv_chan_o <= 1'b0;
            pair_sel_o  <= 1'b0;
            dac_code_o  <= dsar_pkg::CODE_MID;
        end else begin
            busy_o      <= nx_conv;
            chan_done_o <= ~nx_conv_a;
            low_power_o <= nx_low_pwr;
            track_o     <= nx_track;
            conv_chan_o <= nx_conv_b;
            // Pair follows input while tracking, frozen through conversion
            if (nx_track) begin
                pair_sel_o <= input_pair_sel_i;
            end
            dac_code_o  <= nx_dac;
        end
    end

    // ------------------------------------------------------------------
    // Two-entry result buffer
    // ------------------------------------------------------------------
    // Serial side drains only a full pair and only between reads
    // Full count means the loaded pair is shifted out; reset leaves zero
    wire ser_done    = (shift_cnt_q == dsar_pkg::SER_CNT_W'(dsar_pkg::SER_BITS));
    wire ser_active  = (shift_cnt_q != '0) & ~ser_done;
    wire buf_out_vld = (buf_cnt_q != 2'd0);
    wire buf_out_rdy = serial_parallel_sel_i ?
                       (pop_second_q | ((buf_cnt_q == 2'd2) & ~ser_active)) : 1'b1;
    wire buf_rd      = buf_out_vld & buf_out_rdy;
    wire [RES_W-1:0] buf_head = buf_mem_q[buf_rptr_q];
    // Head holds first channel unless it is the second of a pair
    wire head_is_b   = pop_second_q | (~serial_parallel_sel_i & buf_rptr_q);

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            buf_mem_q[0] <= dsar_pkg::CODE_ZERO;
            buf_mem_q[1] <= dsar_pkg::CODE_ZERO;
            buf_wptr_q   <= 1'b0;
            buf_rptr_q   <= 1'b0;
            buf_cnt_q    <= 2'd0;
        end else if (dev_reset_i) begin
            // Stored words are kept; only the flow state clears
            buf_wptr_q   <= 1'b0;
            buf_rptr_q   <= 1'b0;
            buf_cnt_q    <= 2'd0;
        end else begin
            if (buf_wr) begin
                buf_mem_q[buf_wptr_q] <= kept_code;
                buf_wptr_q            <= ~buf_wptr_q;
            end
            if (buf_rd) begin
                buf_rptr_q <= ~buf_rptr_q;
            end
            buf_cnt_q <= buf_cnt_q + {1'b0, buf_wr} - {1'b0, buf_rd};
        end
    end

    // ------------------------------------------------------------------
    // Output words and serial shifter
    // ------------------------------------------------------------------
    wire sclk_rise  = ~sclk_q & serial_clk_i;
    wire bus_en     = ~cs_n_i & ~rd_n_i;
    wire pair_ready = buf_rd & pop_second_q;
    // Host clock rises beyond the last bit are ignored
    wire shift_go   = bus_en & sclk_rise & ~ser_done;
    wire [RES_W-1:0] new_b = head_is_b ? buf_head : word_b_q;
    wire [RES_W-1:0] new_a = head_is_b ? word_a_q : buf_head;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            word_a_q     <= dsar_pkg::CODE_ZERO;
            word_b_q     <= dsar_pkg::CODE_ZERO;
            pop_second_q <= 1'b0;
            shift_q      <= '0;
            shift_cnt_q  <= '0;
            sclk_q       <= 1'b0;
        end else if (dev_reset_i) begin
            // A half-read pair is dropped with the flow state
            pop_second_q <= 1'b0;
            shift_cnt_q  <= '0;
            sclk_q       <= serial_clk_i;
        end else begin
            sclk_q       <= serial_clk_i;
            // Parallel: first channel visible as soon as it lands
            if (buf_rd) begin
                word_a_q <= new_a;
                word_b_q <= new_b;
            end
            pop_second_q <= serial_parallel_sel_i & buf_rd & ~pop_second_q;
            if (pair_ready) begin
                // Order chosen when the pair is loaded
                shift_q     <= chan_pick_i ? {word_a_q, buf_head} :
                                             {buf_head, word_a_q};
                shift_cnt_q <= '0;
            end else if (shift_go) begin
                shift_q     <= {shift_q[dsar_pkg::SER_BITS-2:0], 1'b0};
                shift_cnt_q <= shift_cnt_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Host-facing pins, live in every sequencer state
    // ------------------------------------------------------------------
    wire [RES_W-1:0] sel_word = chan_pick_i ? word_a_q : word_b_q;
    // Swap puts the low byte on the upper lane for 8-bit hosts
    wire [RES_W-1:0] bus_word = byte_order_sel_i ?
        {sel_word[dsar_pkg::LO_BYTE_HI:0], sel_word[RES_W-1:dsar_pkg::HI_BYTE_LO]} :
        sel_word;
    wire par_en = bus_en & ~dev_reset_i & ~serial_parallel_sel_i;
    wire ser_en = bus_en & ~dev_reset_i & serial_parallel_sel_i;

    // Enables follow cs and rd one clock later; tied-low keeps driving
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            data_o          <= dsar_pkg::CODE_ZERO;
            data_oe_o       <= 1'b0;
            serial_out_o    <= 1'b0;
            serial_out_oe_o <= 1'b0;
        end else begin
            data_o          <= bus_word;
            data_oe_o       <= par_en;
            // Line keeps the shifter head even while floated
            serial_out_o    <= shift_q[dsar_pkg::SER_BITS-1];
            serial_out_oe_o <= ser_en;
        end
    end

endmodule : dsar_ctrl

// [tb/dsar_afe_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Analog front end as the SAR loop sees it
// ------------------------------------------------------------
module dsar_afe_model (
    input  wire logic [3:0][15:0] level_i,
    input  wire logic             pair_sel_i,
    input  wire logic             conv_chan_i,
    input  wire logic [15:0]      dac_code_i,
    output logic                  comparator_o
);
    // Held level per pair and channel; first channel is index 0
    wire logic [15:0] held_w = level_i[{pair_sel_i, conv_chan_i}];
    // Plain unsigned compare, so the code found equals the level
    assign comparator_o = (held_w >= dac_code_i);
endmodule : dsar_afe_model

// [tb/dsar_ctrl_assertions.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker of the conversion control
// ------------------------------------------------------------
module dsar_ctrl_chk #(
    parameter int RES_W      = 16,
    parameter int BIT_CYCLES = 2
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic conv_start_n_i,
    input wire logic power_down_in_i,
    input wire logic dev_reset_i,
    input wire logic low_power_mode_i,
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    input wire logic serial_parallel_sel_i,
    input wire logic busy_o,
    input wire logic chan_done_o,
    input wire logic low_power_o,
    input wire logic track_o,
    input wire logic conv_chan_o,
    input wire logic data_oe_o,
    input wire logic serial_out_oe_o
);
    localparam int CONV_CYC = 2 * RES_W * BIT_CYCLES;
    int busy_cnt_q;
    // Busy width counter; cleared whenever busy is low
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) busy_cnt_q <= 0;
        else busy_cnt_q <= busy_o ? busy_cnt_q + 1 : 0;
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    property p_oe_off;
        (cs_n_i || rd_n_i || dev_reset_i) |=> !data_oe_o && !serial_out_oe_o;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("outputs driven while deselected");
    property p_par_oe;
        (!cs_n_i && !rd_n_i && !serial_parallel_sel_i && !dev_reset_i)
            |=> data_oe_o && !serial_out_oe_o;
    endproperty
    a_par_oe: assert property (p_par_oe) else $error("parallel bus not driven");
    property p_ser_oe;
        (!cs_n_i && !rd_n_i && serial_parallel_sel_i && !dev_reset_i)
            |=> serial_out_oe_o && !data_oe_o;
    endproperty
    a_ser_oe: assert property (p_ser_oe) else $error("serial output not driven");
    property p_busy_len;
        $fell(busy_o) && !$past(dev_reset_i) |-> busy_cnt_q == CONV_CYC;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy width wrong");
    property p_first;
        $rose(busy_o) |-> !chan_done_o && !conv_chan_o && !track_o;
    endproperty
    a_first: assert property (p_first) else $error("conversion not on first channel");
    property p_second;
        $rose(conv_chan_o) |-> chan_done_o && busy_o && !$past(chan_done_o);
    endproperty
    a_second: assert property (p_second) else $error("second channel out of order");
    // Buffer still holds a word on the edge after busy falls
    property p_start;
        $fell(conv_start_n_i) && !busy_o && !$past(busy_o) && !power_down_in_i && !dev_reset_i
            && !low_power_mode_i && !serial_parallel_sel_i |=> busy_o;
    endproperty
    a_start: assert property (p_start) else $error("start strobe not taken");
    property p_fullrate;
        $rose(busy_o) && !low_power_mode_i |-> $past(conv_start_n_i, 2) && !$past(conv_start_n_i);
    endproperty
    a_fullrate: assert property (p_fullrate) else $error("start without strobe edge");
    property p_lp;
        busy_o && $past(busy_o) |-> !low_power_o;
    endproperty
    a_lp: assert property (p_lp) else $error("low power while converting");
    property p_abort;
        dev_reset_i |=> !busy_o;
    endproperty
    a_abort: assert property (p_abort) else $error("reset did not abort");
endmodule : dsar_ctrl_chk

bind dsar_ctrl dsar_ctrl_chk #(.RES_W(RES_W), .BIT_CYCLES(BIT_CYCLES)) dsar_ctrl_chk_i (.*);

// [tb/tb.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bench of the dual-channel conversion control
// ------------------------------------------------------------
module tb;
    logic             sys_clk_i = 1'b0;
    logic             nrst_i = 1'b0;
    logic             conv_start_n_i = 1'b1;
    logic             power_down_in_i = 1'b0;
    logic             dev_reset_i = 1'b0;
    logic             low_power_mode_i = 1'b0;
    logic             cs_n_i = 1'b1;
    logic             rd_n_i = 1'b1;
    logic             serial_parallel_sel_i = 1'b0;
    logic             byte_order_sel_i = 1'b0;
    logic             chan_pick_i = 1'b0;
    logic             input_pair_sel_i = 1'b0;
    logic             serial_clk_i = 1'b0;
    logic             comparator_i;
    logic             busy_o, chan_done_o, low_power_o, track_o, conv_chan_o, pair_sel_o;
    logic             data_oe_o, serial_out_o, serial_out_oe_o;
    logic [15:0]      dac_code_o, data_o, a_w, b_w;
    logic [3:0][15:0] lvl = '0;
    logic [15:0]      exp_q[$];
    logic             look = 1'b0;
    logic             ser_m = 1'b0;
    int               fails = 0;
    int               check_count = 0;
    int               seed = 32'h8C66E302;

    dsar_ctrl dsar_ctrl_i (.*);
    dsar_afe_model dsar_afe_model_i (.level_i(lvl), .pair_sel_i(pair_sel_o),
        .conv_chan_i(conv_chan_o), .dac_code_i(dac_code_o), .comparator_o(comparator_i));

    initial forever #20 sys_clk_i = ~sys_clk_i;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("checks %0d errors %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done

    // Inputs always move 2 ns after the rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #2;
    endtask : cyc

    // Bounded wait; a stuck busy ends the run
    task automatic wait_busy(input logic lv);
        int i;
        for (i = 0; i < 200 && busy_o !== lv; i++) cyc(1);
        if (busy_o !== lv) begin
            chk(16'(busy_o), 16'(lv));
            test_done();
        end
    endtask : wait_busy

    task automatic par_read(input logic pick, input logic swap, input logic [15:0] w);
        chan_pick_i = pick;
        byte_order_sel_i = swap;
        cs_n_i = 1'b0;
        rd_n_i = 1'b0;
        exp_q.push_back(swap ? {w[7:0], w[15:8]} : w);
        cyc(2);
        look = 1'b1;
        cyc(1);
        look = 1'b0;
        cs_n_i = 1'b1;
        rd_n_i = 1'b1;
        cyc(1);
    endtask : par_read

    // Host clock slow enough for the sampled serial clock input
    task automatic ser_read(input logic [31:0] s);
        int i;
        cs_n_i = 1'b0;
        rd_n_i = 1'b0;
        ser_m = 1'b1;
        cyc(2);
        for (i = 31; i >= 0; i--) begin
            exp_q.push_back(16'(s[i]));
            look = 1'b1;
            cyc(1);
            look = 1'b0;
            serial_clk_i = 1'b1;
            cyc(2);
            serial_clk_i = 1'b0;
            cyc(2);
        end
        cs_n_i = 1'b1;
        rd_n_i = 1'b1;
        ser_m = 1'b0;
        cyc(1);
    endtask : ser_read

    // New levels only while idle, so inputs are settled at busy fall
    task automatic convert(input logic pair, input logic early);
        int k;
        for (k = 0; k < 4; k++) lvl[k] = 16'($random(seed));
        input_pair_sel_i = pair;
        a_w = lvl[{pair, 1'b0}];
        b_w = lvl[{pair, 1'b1}];
        cyc(1);
        conv_start_n_i = 1'b0;
        cyc(1);
        conv_start_n_i = 1'b1;
        wait_busy(1'b1);
        cyc(10);
        conv_start_n_i = 1'b0; // Stray strobe mid-run, must be ignored
        power_down_in_i = 1'b1;
        cyc(1);
        conv_start_n_i = 1'b1;
        power_down_in_i = 1'b0;
        cyc(24);
        if (early) par_read(1'b1, 1'b0, a_w);
        wait_busy(1'b0);
        cyc(3);
    endtask : convert

    // Monitor takes the oldest note whenever a result is shown
    always @(negedge sys_clk_i) begin
        if (look) begin
            chk(16'(ser_m ? serial_out_oe_o : data_oe_o), 16'h0001);
            chk(ser_m ? 16'(serial_out_o) : data_o, exp_q.pop_front());
        end
    end

    initial begin
        int i;
        cyc(4);
        nrst_i = 1'b1;
        cyc(1);
        chk(16'({busy_o, data_oe_o, chan_done_o, track_o}), 16'h0003);
        for (i = 0; i < 8; i++) begin
            convert(i[2], i[0]);
            par_read(i[1], i[0], i[1] ? a_w : b_w);
        end
        // Abort with the bus enabled
        cs_n_i = 1'b0;
        rd_n_i = 1'b0;
        conv_start_n_i = 1'b0;
        cyc(1);
        conv_start_n_i = 1'b1;
        wait_busy(1'b1);
        cyc(5);
        dev_reset_i = 1'b1;
        cyc(2);
        chk(16'({busy_o, data_oe_o}), 16'h0000);
        dev_reset_i = 1'b0;
        cs_n_i = 1'b1;
        rd_n_i = 1'b1;
        cyc(2);
        // Held strobe repeats only in low-power mode
        low_power_mode_i = 1'b1;
        conv_start_n_i = 1'b0;
        wait_busy(1'b1);
        wait_busy(1'b0);
        cyc(2);
        chk(16'(low_power_o), 16'h0001);
        wait_busy(1'b1);
        conv_start_n_i = 1'b1;
        wait_busy(1'b0);
        low_power_mode_i = 1'b0;
        cyc(2); // Last word leaves the buffer before the next start
        conv_start_n_i = 1'b0;
        wait_busy(1'b1);
        wait_busy(1'b0);
        cyc(40);
        chk(16'(busy_o), 16'h0000);
        conv_start_n_i = 1'b1;
        serial_parallel_sel_i = 1'b1;
        for (i = 0; i < 2; i++) begin
            chan_pick_i = i[0];
            convert(i[0], 1'b0);
            ser_read(i[0] ? {a_w, b_w} : {b_w, a_w});
        end
        test_done();
    end
endmodule : tb
